//--- verilog/cie_exec.sv
// execute sequencer for halt, rotate, subtract, xor and nibble exchange
`timescale 1ns/1ps
`default_nettype none
`include "cie_consts.svh"
module cie_exec
   import cie_pkg::*;
#(
   parameter int REG_DEPTH = `CIE_REG_DEPTH
) (
   // clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   // instruction issue
   input  wire logic       start_in,
   input  wire logic [2:0] opcode_in,
   input  wire logic [6:0] reg_addr_in,
   input  wire logic       dest_in,
   input  wire logic [7:0] literal_in,
   // register preload, idle only
   input  wire logic       load_en_in,
   input  wire logic [7:0] load_data_in,
   // wake from sleep, asynchronous pin
   input  wire logic       wake_in,
   // status and results
   output logic            ready_out,
   output logic            done_out,
   output logic [7:0]      acc_out,
   output logic [7:0]      result_out,
   output logic            borrow_not_flag_out,
   output logic            nibble_borrow_not_flag_out,
   output logic            all_bits_low_flag_out,
   output logic            timeout_flag_out,
   output logic            powerdown_flag_out,
   output logic            watchdog_clear_out,
   output logic            sleep_out
);

   // elaboration check: the address field is fixed at 7 bits
   if (REG_DEPTH != `CIE_REG_DEPTH) begin
      $error("cie_exec: register depth must match the 7-bit address field");
   end

   // ***********************************************************
   // state
   // ***********************************************************
   cie_state_e state_reg;
   cie_op_e    op_reg;
   logic [6:0] addr_reg;
   logic       dest_reg;
   cie_byte_t  lit_reg;
   logic       wake_meta_reg;
   logic       wake_sync_reg;

   cie_rf_if rf_bus ();

   cie_regfile #(.DEPTH(REG_DEPTH)) u_regfile (
      .sys_clk_in (sys_clk_in),
      .rf         (rf_bus.mem)
   );

   // wake pin passes two flops before the sequencer sees it
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wake_meta_reg <= 1'b0;
         wake_sync_reg <= 1'b0;
      end else begin
         wake_meta_reg <= wake_in;
         wake_sync_reg <= wake_meta_reg;
      end
   end

   // ***********************************************************
   // operand capture and datapath
   // ***********************************************************
   logic accept;
   assign accept = (state_reg == CIE_ST_IDLE) && start_in;

   // operands held for the execute cycle
   // seven-bit address, byte literal
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         op_reg   <= CIE_OP_NOP;
         addr_reg <= 7'h00;
         dest_reg <= `CIE_DEST_ACC;
         lit_reg  <= 8'h00;
      end else if (accept) begin
         op_reg   <= cie_op_e'(opcode_in);
         addr_reg <= reg_addr_in;
         dest_reg <= dest_in;
         lit_reg  <= literal_in;
      end
   end

   // read address follows the port so data are ready in the execute cycle
   assign rf_bus.raddr = reg_addr_in;

   cie_byte_t  fval;
   cie_byte_t  res;
   logic [8:0] sub_full;
   logic [4:0] sub_nib;
   cie_byte_t  minuend;
   assign fval    = rf_bus.rdata;
   assign minuend = (op_reg == CIE_OP_LIT_SUB) ? lit_reg : fval;
   // two's complement subtract: carry out is the not-borrow
   assign sub_full = {1'b0, minuend} + {1'b0, ~acc_out} + 9'h001;
   assign sub_nib  = {1'b0, minuend[`CIE_NIB_LO_MSB:`CIE_NIB_LO_LSB]}
                   + {1'b0, ~acc_out[`CIE_NIB_LO_MSB:`CIE_NIB_LO_LSB]} + 5'h01;

   // result selection per operation
   always_comb begin
      case (op_reg)
         CIE_OP_ROTR:    res = {borrow_not_flag_out, fval[`CIE_MSB:1]};
         CIE_OP_LIT_SUB: res = sub_full[7:0];
         CIE_OP_REG_SUB: res = sub_full[7:0];
         CIE_OP_REG_XOR: res = acc_out ^ fval;
         CIE_OP_LIT_XOR: res = acc_out ^ lit_reg;
         CIE_OP_NIB_EX:  res = {fval[`CIE_NIB_LO_MSB:`CIE_NIB_LO_LSB],
                                fval[`CIE_NIB_HI_MSB:`CIE_NIB_HI_LSB]};
         default:        res = acc_out;
      endcase
   end

   logic exec;
   logic is_lit_op;
   logic to_reg;
   assign exec      = (state_reg == CIE_ST_EXEC);
   assign is_lit_op = (op_reg == CIE_OP_LIT_SUB) || (op_reg == CIE_OP_LIT_XOR);
   assign to_reg    = exec && !is_lit_op && (dest_reg == `CIE_DEST_REG)
                      && (op_reg != CIE_OP_HALT) && (op_reg != CIE_OP_NOP);

   // register file write: preload when idle, else write-back
   assign rf_bus.we    = to_reg || ((state_reg == CIE_ST_IDLE) && load_en_in && !start_in);
   assign rf_bus.waddr = to_reg ? addr_reg : reg_addr_in;
   assign rf_bus.wdata = to_reg ? res : load_data_in;

   // ***********************************************************
   // sequencer
   // ***********************************************************
   // halt parks the core until wake
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= CIE_ST_IDLE;
      end else begin
         case (state_reg)
            CIE_ST_IDLE:  if (start_in) state_reg <= CIE_ST_EXEC;
            CIE_ST_EXEC:  state_reg <= (op_reg == CIE_OP_HALT) ? CIE_ST_SLEEP : CIE_ST_IDLE;
            CIE_ST_SLEEP: if (wake_sync_reg) state_reg <= CIE_ST_IDLE;
            default:      state_reg <= CIE_ST_IDLE;
         endcase
      end
   end

   // handshake outputs, all from flops
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ready_out  <= 1'b1;
         done_out   <= 1'b0;
         sleep_out  <= 1'b0;
         result_out <= 8'h00;
      end else begin
         done_out  <= exec;
         sleep_out <= (exec && op_reg == CIE_OP_HALT)
                      || (state_reg == CIE_ST_SLEEP && !wake_sync_reg);
         ready_out <= (state_reg == CIE_ST_IDLE && !start_in)
                      || (exec && op_reg != CIE_OP_HALT)
                      || (state_reg == CIE_ST_SLEEP && wake_sync_reg);
         if (exec) begin
            result_out <= res;
         end
      end
   end

   // accumulator write for literal ops and destination zero
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_out <= `CIE_ACC_RST;
      end else if (exec && !to_reg && op_reg != CIE_OP_HALT && op_reg != CIE_OP_NOP) begin
         acc_out <= res;
      end
   end

   // arithmetic flags, each op touches only its own
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         borrow_not_flag_out        <= `CIE_FLAG_RST;
         nibble_borrow_not_flag_out <= `CIE_FLAG_RST;
         all_bits_low_flag_out      <= `CIE_FLAG_RST;
      end else if (exec) begin
         case (op_reg)
            CIE_OP_ROTR: borrow_not_flag_out <= fval[`CIE_LSB];
            CIE_OP_LIT_SUB, CIE_OP_REG_SUB: begin
               borrow_not_flag_out        <= sub_full[8];
               nibble_borrow_not_flag_out <= sub_nib[4];
               all_bits_low_flag_out      <= (res == 8'h00);
            end
            CIE_OP_REG_XOR, CIE_OP_LIT_XOR: all_bits_low_flag_out <= (res == 8'h00);
            default: ;
         endcase
      end
   end

   // power status and watchdog clear
   // halt side effects
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timeout_flag_out   <= `CIE_TIMEOUT_RST;
         powerdown_flag_out <= `CIE_POWERDOWN_RST;
         watchdog_clear_out <= 1'b0;
      end else begin
         watchdog_clear_out <= exec && (op_reg == CIE_OP_HALT);
         if (exec && op_reg == CIE_OP_HALT) begin
            timeout_flag_out   <= `CIE_TIMEOUT_HALT;
            powerdown_flag_out <= `CIE_POWERDOWN_HALT;
         end
      end
   end

   // ***********************************************************
   // assertions
   // ***********************************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_halt_watchdog;
      exec && op_reg == CIE_OP_HALT |=> watchdog_clear_out ##1 !watchdog_clear_out;
   endproperty
   a_halt_watchdog: assert property (p_halt_watchdog) else $error("halt did not pulse watchdog clear");

   property p_halt_status;
      exec && op_reg == CIE_OP_HALT |=> timeout_flag_out && !powerdown_flag_out
         && $stable(borrow_not_flag_out) && $stable(all_bits_low_flag_out) && $stable(acc_out);
   endproperty
   a_halt_status: assert property (p_halt_status) else $error("halt status bits wrong");

   property p_sleep_hold;
      state_reg == CIE_ST_SLEEP && !wake_sync_reg |=> sleep_out && !ready_out && !done_out;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("core ran while asleep");

   property p_rotr;
      exec && op_reg == CIE_OP_ROTR && dest_reg == `CIE_DEST_ACC |=>
         acc_out == {$past(borrow_not_flag_out), $past(fval[7:1])}
         && borrow_not_flag_out == $past(fval[0]) && $stable(all_bits_low_flag_out);
   endproperty
   a_rotr: assert property (p_rotr) else $error("rotate result wrong");

   property p_dest_reg;
      exec && to_reg |=> $stable(acc_out);
   endproperty
   a_dest_reg: assert property (p_dest_reg) else $error("register destination touched acc");

   property p_lit_sub;
      exec && op_reg == CIE_OP_LIT_SUB |=> acc_out == 8'($past(lit_reg) - $past(acc_out))
         && borrow_not_flag_out == ($past(acc_out) <= $past(lit_reg))
         && nibble_borrow_not_flag_out == ($past(acc_out[3:0]) <= $past(lit_reg[3:0]));
   endproperty
   a_lit_sub: assert property (p_lit_sub) else $error("literal subtract wrong");

   property p_reg_sub;
      exec && op_reg == CIE_OP_REG_SUB |=> result_out == 8'($past(fval) - $past(acc_out))
         && borrow_not_flag_out == ($past(acc_out) <= $past(fval));
   endproperty
   a_reg_sub: assert property (p_reg_sub) else $error("register subtract wrong");

   property p_nib_ex;
      exec && op_reg == CIE_OP_NIB_EX |=> $stable(borrow_not_flag_out)
         && $stable(nibble_borrow_not_flag_out) && $stable(all_bits_low_flag_out)
         && result_out == {$past(fval[3:0]), $past(fval[7:4])};
   endproperty
   a_nib_ex: assert property (p_nib_ex) else $error("nibble exchange wrong");

   property p_xor_zero;
      exec && (op_reg == CIE_OP_LIT_XOR || op_reg == CIE_OP_REG_XOR) |=>
         all_bits_low_flag_out == (result_out == 8'h00) && $stable(borrow_not_flag_out);
   endproperty
   a_xor_zero: assert property (p_xor_zero) else $error("xor zero flag wrong");

   property p_lit_xor;
      exec && op_reg == CIE_OP_LIT_XOR |=> acc_out == ($past(acc_out) ^ $past(lit_reg))
         && $stable(borrow_not_flag_out) && $stable(nibble_borrow_not_flag_out);
   endproperty
   a_lit_xor: assert property (p_lit_xor) else $error("literal xor wrong");

endmodule
`default_nettype wire

//--- verilog/cie_consts.svh
// constants for the instruction execute subset: widths, positions, reset values
`ifndef CIE_CONSTS_SVH
`define CIE_CONSTS_SVH

// ***********************************************************
// data and operand widths
// ***********************************************************
`define CIE_DATA_W      8
`define CIE_ADDR_W      7
`define CIE_REG_DEPTH   128
`define CIE_OP_W        3

// ***********************************************************
// field positions
// ***********************************************************
`define CIE_MSB         7
`define CIE_LSB         0
`define CIE_NIB_HI_MSB  7
`define CIE_NIB_HI_LSB  4
`define CIE_NIB_LO_MSB  3
`define CIE_NIB_LO_LSB  0

// ***********************************************************
// reset and forced values
// ***********************************************************
`define CIE_ACC_RST     8'h00
`define CIE_WATCHDOG_CLEAR   8'h00
`define CIE_FLAG_RST         1'b0
`define CIE_TIMEOUT_RST      1'b1
`define CIE_POWERDOWN_RST    1'b1
`define CIE_TIMEOUT_HALT     1'b1
`define CIE_POWERDOWN_HALT   1'b0
`define CIE_DEST_ACC    1'b0
`define CIE_DEST_REG    1'b1

`endif

//--- verilog/cie_pkg.sv
// types shared by the instruction execute subset
package cie_pkg;

   // instruction select presented on the opcode port
   typedef enum logic [2:0] {
      CIE_OP_NOP     = 3'b000,
      CIE_OP_HALT    = 3'b001,
      CIE_OP_ROTR    = 3'b010,
      CIE_OP_LIT_SUB = 3'b011,
      CIE_OP_REG_SUB = 3'b100,
      CIE_OP_REG_XOR = 3'b101,
      CIE_OP_NIB_EX  = 3'b110,
      CIE_OP_LIT_XOR = 3'b111
   } cie_op_e;

   // sequencer states
   typedef enum logic [1:0] {
      CIE_ST_IDLE  = 2'b00,
      CIE_ST_EXEC  = 2'b01,
      CIE_ST_SLEEP = 2'b10
   } cie_state_e;

   typedef logic [7:0] cie_byte_t;

endpackage

//--- verilog/cie_rf_if.sv
// carrier between the sequencer and its register file
`timescale 1ns/1ps
`default_nettype none
interface cie_rf_if;
   logic       we;
   logic [6:0] waddr;
   logic [7:0] wdata;
   logic [6:0] raddr;
   logic [7:0] rdata;

   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

//--- verilog/cie_regfile.sv
// file register storage with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "cie_consts.svh"
module cie_regfile
   import cie_pkg::*;
#(
   parameter int DEPTH = `CIE_REG_DEPTH
) (
   // clock
   input wire logic sys_clk_in,
   // access port
   cie_rf_if.mem    rf
);

   // the address field is 7 bits, so more than 128 words cannot be reached
   if (DEPTH < 1 || DEPTH > `CIE_REG_DEPTH) begin
      $error("cie_regfile: DEPTH out of range");
   end

   cie_byte_t mem_reg [DEPTH];
   cie_byte_t rdata_reg;

   // write port; no reset so the array maps onto plain ram
   always_ff @(posedge sys_clk_in) begin
      if (rf.we) begin
         mem_reg[rf.waddr] <= rf.wdata;
      end
   end

   // read data come from a flop, one cycle after the address
   always_ff @(posedge sys_clk_in) begin
      rdata_reg <= mem_reg[rf.raddr];
   end

   assign rf.rdata = rdata_reg;

endmodule
`default_nettype wire

//--- sim/cie_tb.sv
// self-checking bench for the execute subset, with an integer reference model
`timescale 1ns/1ps
`default_nettype none
module testbench
   import cie_pkg::*;
;
   // ***********************************************************
   // stimulus and observed signals
   // ***********************************************************
   logic        sys_clk_in, rst_n_in, start_in, dest_in, load_en_in, wake_in;
   logic [2:0]  opcode_in;
   logic [6:0]  reg_addr_in;
   logic [7:0]  literal_in, load_data_in, acc_out, result_out;
   logic        ready_out, done_out, borrow_not_flag_out, nibble_borrow_not_flag_out;
   logic        all_bits_low_flag_out, timeout_flag_out, powerdown_flag_out, watchdog_clear_out, sleep_out;
   int          bad_count, n_tests, i;
   int          mem[128];
   int          m_acc, m_c, m_nib, m_z, m_tmo, m_pwr;
   logic [31:0] seed;

   cie_exec u_cie_exec (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(start_in),
      .opcode_in(opcode_in), .reg_addr_in(reg_addr_in), .dest_in(dest_in), .literal_in(literal_in),
      .load_en_in(load_en_in), .load_data_in(load_data_in), .wake_in(wake_in), .ready_out(ready_out),
      .done_out(done_out), .acc_out(acc_out), .result_out(result_out),
      .borrow_not_flag_out(borrow_not_flag_out), .nibble_borrow_not_flag_out(nibble_borrow_not_flag_out),
      .all_bits_low_flag_out(all_bits_low_flag_out), .timeout_flag_out(timeout_flag_out),
      .powerdown_flag_out(powerdown_flag_out), .watchdog_clear_out(watchdog_clear_out), .sleep_out(sleep_out));

   // 100 MHz clock
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   // galois shift register, fixed start so runs repeat
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
   endfunction

   // one comparison; case inequality so unknowns never match
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // status flags and accumulator against the model
   task automatic chk_state();
      chk("acc", 8'(m_acc), acc_out);
      chk("borrow", 8'(m_c), 8'(borrow_not_flag_out));
      chk("nibble", 8'(m_nib), 8'(nibble_borrow_not_flag_out));
      chk("zero", 8'(m_z), 8'(all_bits_low_flag_out));
      chk("timeout", 8'(m_tmo), 8'(timeout_flag_out));
      chk("powerdown", 8'(m_pwr), 8'(powerdown_flag_out));
   endtask

   // hold reset 12 cycles; register file keeps its contents
   task automatic do_reset();
      @(posedge sys_clk_in);
      rst_n_in <= 1'b0;
      repeat (12) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      m_acc = 0;
      m_c = 0;
      m_nib = 0;
      m_z = 0;
      m_tmo = 1;
      m_pwr = 1;
      #1;
      chk("ready", 8'h01, 8'(ready_out));
      chk("sleep", 8'h00, 8'(sleep_out));
      chk_state();
   endtask

   // preload one register while idle
   task automatic preload(input int a, input int d);
      @(posedge sys_clk_in);
      load_en_in   <= 1'b1;
      reg_addr_in  <= a[6:0];
      load_data_in <= d[7:0];
      @(posedge sys_clk_in);
      load_en_in <= 1'b0;
      mem[a] = d;
   endtask

   // issue one instruction; a preload rides along and must be ignored
   task automatic run_op(input int op, input int a, input int d, input int k);
      logic [7:0] w, f, r, kk;
      int         n;
      w = 8'(m_acc);
      f = 8'(mem[a]);
      kk = 8'(k);
      r = 8'h00;
      @(posedge sys_clk_in);
      start_in     <= 1'b1;
      opcode_in    <= op[2:0];
      reg_addr_in  <= a[6:0];
      dest_in      <= d[0];
      literal_in   <= kk;
      load_en_in   <= 1'b1;
      load_data_in <= ~f;
      @(posedge sys_clk_in);
      start_in <= 1'b0;
      @(posedge sys_clk_in);
      load_en_in <= 1'b0;
      #1;
      case (op)
         1: begin
            m_tmo = 1;
            m_pwr = 0;
         end
         2: begin
            r = {m_c[0], f[7:1]};
            m_c = f[0];
         end
         3, 4: begin
            if (op == 4) kk = f;
            r = kk - w;
            m_c = (w <= kk);
            m_nib = (w[3:0] <= kk[3:0]);
         end
         5: r = w ^ f;
         6: r = {f[3:0], f[7:4]};
         7: r = w ^ kk;
         default: r = 8'h00;
      endcase
      if (op == 3 || op == 4 || op == 5 || op == 7) m_z = (r == 8'h00);
      if (op == 3 || op == 7 || ((op == 2 || op >= 4) && op != 7 && d == 0)) m_acc = r;
      else if (op >= 2) mem[a] = r;
      chk("done", 8'h01, 8'(done_out));
      if (op >= 2) chk("result", r, result_out);
      chk_state();
      chk("watchdog_clear", 8'(op == 1), 8'(watchdog_clear_out));
      chk("sleep", 8'(op == 1), 8'(sleep_out));
      chk("ready", 8'(op != 1), 8'(ready_out));
      if (op == 1) begin
         // asleep: a start must be refused
         @(posedge sys_clk_in);
         start_in   <= 1'b1;
         opcode_in  <= 3'h7;
         literal_in <= 8'h5a;
         @(posedge sys_clk_in);
         start_in <= 1'b0;
         repeat (2) @(posedge sys_clk_in);
         #1;
         chk("done", 8'h00, 8'(done_out));
         chk_state();
         @(posedge sys_clk_in);
         wake_in <= 1'b1;
         n = 0;
         while (sleep_out === 1'b1 && n < 8) begin
            @(posedge sys_clk_in);
            #1;
            n++;
         end
         chk("wake_edges", 8'h03, 8'(n));
         chk("ready", 8'h01, 8'(ready_out));
         // drop the wake pin on an edge, at least two edges before any later halt executes
         @(posedge sys_clk_in);
         wake_in <= 1'b0;
      end
   endtask

   // closing report and verdict
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // watchdog: the sequence needs a few thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk_in);
      bad_count++;
      wrap_up();
   end

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      {start_in, dest_in, load_en_in, wake_in, opcode_in, reg_addr_in} = '0;
      literal_in = 8'h00;
      load_data_in = 8'h00;
      rst_n_in = 1'b0;
      bad_count = 0;
      n_tests = 0;
      seed = 32'h10caa63a;
      do_reset();
      // every register address, 0 through 127
      for (i = 0; i < 128; i++) begin
         seed = lfsr_next(seed);
         preload(i, int'(seed[7:0]));
      end
      // boundary subtracts: equal, zero, accumulator above literal
      run_op(7, 0, 0, 8'h5a);
      run_op(3, 0, 0, 8'h5a);
      run_op(7, 0, 0, 8'h11);
      run_op(3, 0, 0, 8'h10);
      run_op(3, 0, 0, 8'hff);
      run_op(4, 127, 1, 0);
      run_op(1, 0, 0, 0);
      // every opcode, random fields
      for (i = 0; i < 400; i++) begin
         seed = lfsr_next(seed);
         run_op(int'(seed[2:0]), int'(seed[14:8]), int'(seed[16]), int'(seed[31:24]));
      end
      // second reset in mid-run restores power status bits
      do_reset();
      run_op(2, 5, 0, 0);
      wrap_up();
   end
endmodule
`default_nettype wire
